// ### sah_defs.svh
`ifndef SAH_DEFS_SVH
`define SAH_DEFS_SVH
// register byte offsets
`define SAH_OFS_CTRL 8'h00
`define SAH_OFS_CFG 8'h04
`define SAH_OFS_SPEED 8'h08
`define SAH_OFS_START_STOP_FREQUENCY 8'h0c
`define SAH_OFS_JOG 8'h10
`define SAH_OFS_SCALE 8'h14
`define SAH_OFS_PRESET 8'h18
`define SAH_OFS_RP_VAL 8'h1c
`define SAH_OFS_CMD 8'h20
`define SAH_OFS_STATUS 8'h24
`define SAH_OFS_POS 8'h28
`define SAH_OFS_IRQ_ST 8'h2c
`define SAH_OFS_IRQ_MASK 8'h30
`define SAH_OFS_FREQ 8'h34
// output object bit positions
`define SAH_BIT_BRAKE 13
`define SAH_BIT_BOOST 14
// config fields
`define SAH_CFG_AUTO_BOOST 0
`define SAH_CFG_INV_BOOST 1
`define SAH_CFG_AUTO_BRAKE 2
`define SAH_CFG_INV_BRAKE 3
`define SAH_CFG_EVT_EN 4
`define SAH_CFG_MANUAL 5
`define SAH_CFG_HOME_LSB 8
`define SAH_CFG_TASK_LSB 16
// command codes
`define SAH_INSTR_HOME 8'h0e
`define SAH_CMD_HOME_BIT 0
`define SAH_CMD_FORCE_BIT 1
`define SAH_CMD_AUTO_BIT 2
// interrupt bits
`define SAH_IRQ_HOMED 0
`define SAH_IRQ_FORCED 1
// slowest generable frequency in the range
`define SAH_MIN_FREQ 24'h000001
`define SAH_PHASE_NS 100000
`define SAH_PHASE_CYC (`SAH_PHASE_NS / 100)
`endif

// ### sah_pkg.sv
package sah_pkg;
  typedef enum logic [2:0] {
    SAH_SHORT_POS = 3'h0,
    SAH_SHORT_NEG = 3'h1,
    SAH_LONG_POS = 3'h2,
    SAH_LONG_NEG = 3'h3,
    SAH_LIMIT_POS = 3'h4,
    SAH_LIMIT_NEG = 3'h5
  } sah_home_e;
  typedef enum logic [3:0] {
    SAH_IDLE = 4'b0001,
    SAH_SEEK = 4'b0010,
    SAH_FINAL = 4'b0100,
    SAH_DONE = 4'b1000
  } sah_state_e;
  typedef struct packed {
    logic cam;
    logic limit_pos;
    logic limit_neg;
  } sah_sense_s;
  typedef struct packed {
    logic moving;
    logic ramping;
  } sah_motion_s;
endpackage

// ### sah_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser, one per bit
module sah_sync #(
  parameter int W = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule

// ### sah_top.sv
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sah_defs.svh"
module sah_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sah_pkg::sah_sense_s sense,
  input wire sah_pkg::sah_motion_s motion,
  output logic boost_out,
  output logic brake_out,
  output logic move_req,
  output logic move_dir,
  output logic [23:0] move_freq,
  output logic event_req,
  output logic [6:0] event_task,
  output logic irq
);
  import sah_pkg::*;

  logic [15:0] ctrl_q;
  logic [31:0] cfg_q;
  logic [23:0] speed_q, ss_q, jog_q;
  logic [7:0] scale_q;
  logic [31:0] preset_q, rp_val_q, pos_q;
  logic [1:0] irq_st_q, irq_mask_q;
  logic referenced_q;
  sah_state_e state_q;
  sah_sense_s sense_s;
  sah_home_e htype;
  logic aw_q, w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go, home_go, force_go, cam_hit, edge_seen;
  logic [31:0] wmask, rdata_d;
  logic [23:0] approach, final_f, ss_eff;
  logic [31:0] scaled;
  logic [1:0] irq_set;

  sah_sync #(.W(3)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(sense),
    .q(sense_s)
  );

  // write channel: address and data taken in either order
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > `SAH_OFS_FREQ || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte-enable mask
  for (genvar i = 0; i < 4; i++) begin : g_mask
    assign wmask[i*8 +: 8] = {8{wstrb_q[i]}};
  end

  // configuration and data registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 16'h0;
      cfg_q <= 32'h0;
      speed_q <= 24'h0;
      ss_q <= 24'h0;
      jog_q <= 24'h0;
      scale_q <= 8'h64;
      preset_q <= 32'h0;
      rp_val_q <= 32'h0;
      irq_mask_q <= 2'h0;
    end else if (wr_go) begin
      unique case (awaddr_q)
        `SAH_OFS_CTRL: ctrl_q <= (wdata_q[15:0] & wmask[15:0]) | (ctrl_q & ~wmask[15:0]);
        `SAH_OFS_CFG: cfg_q <= (wdata_q & wmask) | (cfg_q & ~wmask);
        `SAH_OFS_SPEED: speed_q <= wdata_q[23:0];
        `SAH_OFS_START_STOP_FREQUENCY: ss_q <= wdata_q[23:0];
        `SAH_OFS_JOG: jog_q <= wdata_q[23:0];
        `SAH_OFS_SCALE: scale_q <= wdata_q[7:0];
        `SAH_OFS_PRESET: preset_q <= wdata_q;
        `SAH_OFS_RP_VAL: rp_val_q <= wdata_q;
        `SAH_OFS_IRQ_MASK: irq_mask_q <= wdata_q[1:0];
        default: ;
      endcase
    end
  end

  // command register: instruction 14 (auto) or manual home command
  assign home_go = wr_go && awaddr_q == `SAH_OFS_CMD && state_q == SAH_IDLE &&
    (cfg_q[`SAH_CFG_MANUAL] ? wdata_q[`SAH_CMD_HOME_BIT]
                            : (wdata_q[`SAH_CMD_AUTO_BIT] && wdata_q[15:8] == `SAH_INSTR_HOME));
  assign force_go = wr_go && awaddr_q == `SAH_OFS_CMD && state_q == SAH_IDLE &&
    wdata_q[`SAH_CMD_FORCE_BIT];
  assign htype = sah_home_e'(cfg_q[`SAH_CFG_HOME_LSB +: 3]);

  // speed selection
  always_comb begin
    scaled = (cfg_q[`SAH_CFG_MANUAL] ? {8'h0, jog_q} : {8'h0, speed_q}) * {24'h0, scale_q};
    approach = scaled[30:7]; // scale factor 128 is unity
    ss_eff = (ss_q == 24'h0) ? `SAH_MIN_FREQ : ss_q;
    final_f = (htype == SAH_SHORT_POS) ? approach : ss_eff;
  end

  // reference detector per variant
  always_comb begin
    unique case (htype)
      SAH_LIMIT_POS: cam_hit = sense_s.limit_pos;
      SAH_LIMIT_NEG: cam_hit = sense_s.limit_neg;
      default: cam_hit = sense_s.cam;
    endcase
    edge_seen = (state_q == SAH_SEEK) ? cam_hit : !cam_hit;
  end

  // homing sequence: seek detector at approach speed, leave it at final speed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SAH_IDLE;
      move_req <= 1'b0;
      move_dir <= 1'b0;
      move_freq <= 24'h0;
    end else begin
      unique case (state_q)
        SAH_IDLE: begin
          move_req <= 1'b0;
          if (home_go) begin
            state_q <= SAH_SEEK;
            move_req <= 1'b1;
            move_dir <= !htype[0];
            move_freq <= approach;
          end
        end
        SAH_SEEK: begin
          if (edge_seen) begin
            state_q <= SAH_FINAL;
            move_dir <= htype[0];
            move_freq <= final_f;
          end
        end
        SAH_FINAL: begin
          if (edge_seen) begin
            state_q <= SAH_DONE;
            move_req <= 1'b0;
          end
        end
        SAH_DONE: state_q <= SAH_IDLE;
      endcase
    end
  end

  // position and referenced flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 32'h0;
      referenced_q <= 1'b0;
    end else if (force_go) begin
      pos_q <= preset_q;
      referenced_q <= 1'b1;
    end else if (state_q == SAH_DONE) begin
      pos_q <= rp_val_q;
      referenced_q <= 1'b1;
    end
  end

  // auxiliary outputs: program bit always effective, auto adds motion state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      boost_out <= 1'b0;
      brake_out <= 1'b1;
    end else begin
      boost_out <= (ctrl_q[`SAH_BIT_BOOST] ||
        (cfg_q[`SAH_CFG_AUTO_BOOST] && motion.ramping)) ^ cfg_q[`SAH_CFG_INV_BOOST];
      brake_out <= !(ctrl_q[`SAH_BIT_BRAKE] ||
        (cfg_q[`SAH_CFG_AUTO_BRAKE] && !motion.moving)) ^ cfg_q[`SAH_CFG_INV_BRAKE];
    end
  end

  // event task binding, pulse on each completed reference
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_req <= 1'b0;
      event_task <= 7'h0;
    end else begin
      event_task <= cfg_q[`SAH_CFG_TASK_LSB +: 7];
      event_req <= cfg_q[`SAH_CFG_EVT_EN] && (state_q == SAH_DONE || force_go);
    end
  end

  // sticky interrupts, set wins over write-one clear
  assign irq_set = {force_go, state_q == SAH_DONE};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (wr_go && awaddr_q == `SAH_OFS_IRQ_ST) begin
        irq_st_q <= (irq_st_q & ~wdata_q[1:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      irq <= |(irq_st_q & irq_mask_q);
    end
  end

  // read mux
  always_comb begin
    unique case (s_axi_araddr)
      `SAH_OFS_CTRL: rdata_d = {16'h0, ctrl_q};
      `SAH_OFS_CFG: rdata_d = cfg_q;
      `SAH_OFS_SPEED: rdata_d = {8'h0, speed_q};
      `SAH_OFS_START_STOP_FREQUENCY: rdata_d = {8'h0, ss_q};
      `SAH_OFS_JOG: rdata_d = {8'h0, jog_q};
      `SAH_OFS_SCALE: rdata_d = {24'h0, scale_q};
      `SAH_OFS_PRESET: rdata_d = preset_q;
      `SAH_OFS_RP_VAL: rdata_d = rp_val_q;
      `SAH_OFS_STATUS: rdata_d = {23'h0, sense_s, referenced_q, state_q, 1'b0};
      `SAH_OFS_POS: rdata_d = pos_q;
      `SAH_OFS_IRQ_ST: rdata_d = {30'h0, irq_st_q};
      `SAH_OFS_IRQ_MASK: rdata_d = {30'h0, irq_mask_q};
      `SAH_OFS_FREQ: rdata_d = {8'h0, move_freq};
      default: rdata_d = 32'h0;
    endcase
  end

  // read channel: one cycle to accept, data next
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= (s_axi_araddr > `SAH_OFS_FREQ || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  sequence s_done;
    state_q == SAH_DONE;
  endsequence
  chk_home_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_done |=> referenced_q && pos_q == $past(rp_val_q)) else $error("home load");
  chk_boost_manual: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cfg_q[0] && !cfg_q[1] |=> boost_out == $past(ctrl_q[14])) else $error("boost");
  chk_boost_auto: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_q[0] && !cfg_q[1] && motion.ramping |=> boost_out) else $error("auto boost");
  chk_boost_inv: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_q[1] && ctrl_q[14] |=> !boost_out) else $error("boost inv");
  chk_brake_manual: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !cfg_q[2] && !cfg_q[3] |=> brake_out == !$past(ctrl_q[13])) else $error("brake");
  chk_brake_auto: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_q[2] && !cfg_q[3] && !motion.moving |=> !brake_out) else $error("auto brake");
  chk_home_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    home_go |=> state_q == SAH_SEEK && move_req) else $error("home start");
  chk_force_pos: assert property (@(posedge ref_clk) disable iff (!rst_n)
    force_go |=> pos_q == $past(preset_q) && !move_req) else $error("force");
  chk_final_freq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == SAH_SEEK && edge_seen && ss_q == 24'h0 && htype != SAH_SHORT_POS
    |=> move_freq == 24'h000001) else $error("final freq");
  chk_event_task: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 event_task == $past(cfg_q[22:16])) else $error("task");
endmodule

// ### sah_xlat_model.sv
`timescale 1ns/1ps
// translator model: one step per cycle while motion is requested
module sah_xlat_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic move_req,
  input wire logic move_dir,
  input wire logic [7:0] start_pos,
  output sah_pkg::sah_sense_s sense,
  output sah_pkg::sah_motion_s motion
);
  import sah_pkg::*;
  logic [7:0] pos_q;
  logic [1:0] ramp_q;
  // carriage position and ramp phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= start_pos;
      ramp_q <= 2'h0;
    end else begin
      pos_q <= move_req ? (move_dir ? pos_q + 8'h01 : pos_q - 8'h01) : pos_q;
      ramp_q <= !move_req ? 2'h0 : (ramp_q == 2'h3) ? ramp_q : ramp_q + 2'h1;
    end
  end
  // cam band lies between the two travel limits
  // packed order: cam, limit_pos, limit_neg
  assign sense = {(pos_q >= 8'h46) && (pos_q <= 8'h50), pos_q >= 8'h78, pos_q <= 8'h0a};
  // speed ramps only over the first cycles of a move; packed order: moving, ramping
  assign motion = {move_req, move_req && (ramp_q != 2'h3)};
endmodule

// ### stepper_aux_outputs_and_homing_tb.sv
`timescale 1ns/1ps
`include "sah_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module stepper_aux_outputs_and_homing_tb;
  import sah_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, start_pos = 8'h32;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq, boost_out, brake_out;
  logic move_req, move_dir, event_req, app_dir;
  logic [1:0] bresp, rresp;
  logic [23:0] move_freq, app_f, fin_f, exp_f;
  logic [6:0] event_task, ev_task;
  sah_sense_s sense;
  sah_motion_s motion;
  int fail_count = 0;
  int n_tests = 0;
  int mv_cnt, boost_cnt, brake_cnt, ev_cnt;
  always #50 ref_clk = ~ref_clk;
  sah_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .sense(sense),
    .motion(motion), .boost_out(boost_out), .brake_out(brake_out), .move_req(move_req),
    .move_dir(move_dir), .move_freq(move_freq), .event_req(event_req),
    .event_task(event_task), .irq(irq));
  sah_xlat_model u_xlat (.ref_clk(ref_clk), .rst_n(rst_n), .move_req(move_req),
    .move_dir(move_dir), .start_pos(start_pos), .sense(sense), .motion(motion));
  // one write; address and data are released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // wait for the response; only the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    `CHK("bresp", er, bresp)
  endtask
  // one read, compared under a mask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                    input logic [1:0] er = 2'h0);
    araddr <= a;
    arvalid <= 1'b1;
    // data and response are taken at the edge where rvalid is seen
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    `CHK("rresp", er, rresp)
    `CHK("rdata", e, rdata & m)
  endtask
  // reset with the carriage at a chosen spot
  task automatic rst(input logic [7:0] sp);
    start_pos <= sp;
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    mv_cnt = 0;
    boost_cnt = 0;
    brake_cnt = 0;
    ev_cnt = 0;
    app_f = 24'h0;
    fin_f = 24'h0;
    @(posedge ref_clk);
  endtask
  // wait for a homing move to start and finish
  task automatic wdone;
    int n;
    for (n = 0; !move_req && n < 40; n++) @(posedge ref_clk);
    for (n = 0; move_req && n < 600; n++) @(posedge ref_clk);
    `CHK("home_end", 1'b0, move_req)
    repeat (4) @(posedge ref_clk);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // record approach and final speeds, output activity and events
  always @(posedge ref_clk) begin
    if (move_req) begin
      mv_cnt <= mv_cnt + 1;
      boost_cnt <= boost_cnt + boost_out;
      brake_cnt <= brake_cnt + brake_out;
      if (mv_cnt == 0) app_f <= move_freq;
      if (mv_cnt == 0) app_dir <= move_dir;
      if (mv_cnt != 0 && move_dir !== app_dir) fin_f <= move_freq;
    end
    if (event_req) begin
      ev_cnt <= ev_cnt + 1;
      ev_task <= event_task;
    end
  end
  initial begin
    rst(8'h32);
    rc(`SAH_OFS_SCALE, 32'h64);
    rc(8'h40, 32'h0, '1, 2'h2);
    wr(8'h02, 32'h1, 2'h2);
    // command bits drive boost and brake under each inversion setting
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        wr(`SAH_OFS_CFG, {28'h0, c[1], 1'b0, c[0], 1'b0});
        wr(`SAH_OFS_CTRL, k ? 32'h6000 : 32'h0);
        repeat (3) @(posedge ref_clk);
        `CHK("boost", k[0] ^ c[0], boost_out)
        `CHK("brake", ~k[0] ^ c[1], brake_out)
      end
    end
    // every homing variant, automatic and manual start, control bits left clear
    for (int v = 0; v < 6; v++) begin
      rst(v[0] ? 8'h64 : 8'h32);
      exp_f = v[0] ? ((v == 3) ? 24'hc8 : 24'h190) : 24'h12c;
      wr(`SAH_OFS_CFG, {9'h0, 7'h78 + v[6:0], 5'h0, v[2:0], 2'h0, v[0], 5'h15});
      wr(`SAH_OFS_SPEED, 32'h12c);
      wr(`SAH_OFS_JOG, 32'h190);
      wr(`SAH_OFS_START_STOP_FREQUENCY, (v == 1) ? 32'h0 : 32'h37);
      wr(`SAH_OFS_SCALE, (v == 3) ? 32'h40 : 32'h80);
      wr(`SAH_OFS_RP_VAL, 32'h3e8 + v);
      wr(`SAH_OFS_IRQ_MASK, 32'h1);
      wr(`SAH_OFS_CMD, v[0] ? 32'h1 : {16'h0, `SAH_INSTR_HOME, 8'h04});
      wdone;
      `CHK("dir", ~v[0], app_dir)
      `CHK("approach", exp_f, app_f)
      `CHK("final", (v == 0) ? exp_f : (v == 1) ? `SAH_MIN_FREQ : 24'h37, fin_f)
      `CHK("boost_ramp", 1'b1, boost_cnt > 0 && boost_cnt < 8)
      `CHK("brake_move", 1'b1, brake_cnt + 3 > mv_cnt)
      `CHK("boost_idle", 1'b0, boost_out)
      `CHK("brake_idle", 1'b0, brake_out)
      `CHK("event", 1, ev_cnt)
      `CHK("task", 7'h78 + v[6:0], ev_task)
      `CHK("irq_home", 1'b1, irq)
      rc(`SAH_OFS_POS, 32'h3e8 + v);
      rc(`SAH_OFS_STATUS, 32'h20, 32'h20);
    end
    // forced position with a limit homing type configured
    rst(8'h32);
    wr(`SAH_OFS_CFG, 32'h410);
    wr(`SAH_OFS_PRESET, 32'h1234);
    wr(`SAH_OFS_CMD, 32'h2);
    repeat (5) @(posedge ref_clk);
    `CHK("no_move", 0, mv_cnt)
    `CHK("event_force", 1, ev_cnt)
    rc(`SAH_OFS_POS, 32'h1234);
    rc(`SAH_OFS_STATUS, 32'h20, 32'h20);
    `CHK("irq_masked", 1'b0, irq)
    rc(`SAH_OFS_IRQ_ST, 32'h2);
    wr(`SAH_OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    `CHK("irq_unmasked", 1'b1, irq)
    wr(`SAH_OFS_IRQ_ST, 32'h2);
    repeat (2) @(posedge ref_clk);
    `CHK("irq_cleared", 1'b0, irq)
    rc(`SAH_OFS_IRQ_ST, 32'h0);
    end_sim;
  end
  // cut a hang short
  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    end_sim;
  end
endmodule
